/* File: src/gpx_defs.svh */
// register offsets, field positions, reset values and sensitivity codes
// of the general-purpose port; included by the port and detector modules, not by the package
`ifndef GPX_DEFS_SVH
`define GPX_DEFS_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define GPX_OFF_DATA 2'h0
`define GPX_OFF_DIR 2'h1
`define GPX_OFF_OPT 2'h2
`define GPX_OFF_SENS 2'h3

// ***************************************************************
// reset values
// ***************************************************************
`define GPX_RST_PORT 8'h00
`define GPX_RST_SENS 4'h0

// ***************************************************************
// sensitivity field: two bits per vector
// ***************************************************************
`define GPX_SENS_V0_LSB 0
`define GPX_SENS_V1_LSB 2
`define GPX_SENS_FALL_LOW 2'h0
`define GPX_SENS_RISE 2'h1
`define GPX_SENS_FALL 2'h2
`define GPX_SENS_BOTH 2'h3

`endif

/* File: src/gpx_evt_det.sv */
// one pin's event detector: low level, rising, falling or both edges
// assumes a pin level synchronous to sys_clk_i
`timescale 1ns/1ps
`include "gpx_defs.svh"

module gpx_evt_det (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic pin_i,
    input wire logic en_i,
    input wire logic [1:0] sens_i,
    output logic evt_o
);

    gpx_pkg::gpx_det_t s_r;
    gpx_pkg::gpx_det_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.prev = pin_i;
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // edge history runs while disabled, so no stale edge on enable
    always_comb begin
        case (sens_i)
            `GPX_SENS_FALL_LOW: evt_o = en_i & ~pin_i;
            `GPX_SENS_RISE: evt_o = en_i & pin_i & ~s_r.prev;
            `GPX_SENS_FALL: evt_o = en_i & ~pin_i & s_r.prev;
            default: evt_o = en_i & (pin_i ^ s_r.prev);
        endcase
    end

endmodule // gpx_evt_det

/* File: src/gpx_pkg.sv */
// types shared by the port and its event detectors
// assumes gpx_defs.svh sits in the include path
package gpx_pkg;

    // ***************************************************************
    // software-visible configuration
    // ***************************************************************
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] opt;
        logic [3:0] sens;
    } gpx_regs_t;

    // ***************************************************************
    // whole state of the port
    // ***************************************************************
    typedef struct packed {
        gpx_regs_t regs;
        logic [1:0] pend;
        logic [7:0] rdata;
    } gpx_state_t;

    // ***************************************************************
    // state of one event detector
    // ***************************************************************
    typedef struct packed {
        logic prev;
    } gpx_det_t;

endpackage

/* File: src/gpx_port.sv */
// eight-pin general-purpose port with external interrupt detection
// assumes pins synchronous to sys_clk_i and a plain one-cycle register port
//
// Operation
// - bit n of data, direction and option serves pin n only; eight pins
// - direction 0 makes an input; data reads return the live pin
// - data writes on inputs touch only the latch, never the pin
// - direction 1 drives from the latch; data reads return the latch
// - push-pull drives 0 and 1; open-drain drives 0, releases on 1
// - standard pins: 00 float in, 01 pull-up in, 10 open-drain, 11 push-pull
// - interrupt pins with pull-up: option 1 input is pull-up with interrupt
// - interrupt pins without pull-up: option 1 input is floating with interrupt
// - each interrupt pin raises its own event, sensitivity chosen by software
// - events detected per pin, then ORed per vector
// - hidden pending latch clears on vector fetch or sensitivity change
// - request reaches cpu only in interrupt mode and cpu mask clear
// - events wake both low-power modes; those modes leave the port alone
// - an active peripheral overrides the normal pin configuration
// - a peripheral driving a pin makes it an output, push-pull or open-drain
// - peripheral inputs need input mode; pin stays readable through data
// - input pin driven by peripheral reads back the peripheral's value
// - output pin feeds the data latch to the peripheral's input
// - true open-drain pins: no option, no pull-up, no high drive
`timescale 1ns/1ps
`include "gpx_defs.svh"

module gpx_port #(
    parameter logic [7:0] IRQ_CAP = 8'h00,
    parameter logic [7:0] HAS_PULLUP = 8'hff,
    parameter logic [7:0] TRUE_OD = 8'h00,
    parameter logic [7:0] VEC_SEL = 8'h00
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [7:0] pad_in_i,
    output logic [7:0] pad_out_o,
    output logic [7:0] pad_oe_o,
    output logic [7:0] pad_pullup_o,
    input wire logic [7:0] alt_drive_i,
    input wire logic [7:0] alt_out_i,
    input wire logic [7:0] alt_od_i,
    output logic [7:0] alt_in_o,
    input wire logic cpu_irq_mask_i,
    input wire logic [1:0] irq_ack_i,
    output logic [1:0] irq_req_o,
    output logic wake_o
);

    // ***************************************************************
    // state and per-pin decode
    // ***************************************************************
    gpx_pkg::gpx_state_t s_r;
    gpx_pkg::gpx_state_t s_nxt;

    logic [7:0] irq_en;
    logic [7:0] pin_evt;
    logic [1:0] vec_evt;
    logic [1:0] sens_chg;
    logic [3:0] sens_wr;

    // push-pull only where an option bit exists
    function automatic logic [7:0] push_pull(input logic [7:0] dir, input logic [7:0] opt);
        push_pull = dir & opt & ~TRUE_OD;
    endfunction

    // value seen on a data read, bit by bit
    function automatic logic [7:0] data_view(input gpx_pkg::gpx_regs_t r,
                                             input logic [7:0] pin,
                                             input logic [7:0] aen,
                                             input logic [7:0] aout);
        data_view = (r.dir & r.data)
                  | (~r.dir & aen & aout)
                  | (~r.dir & ~aen & pin);
    endfunction

    // option 1 on an input turns the interrupt on, pull-up or floating
    assign irq_en = ~s_r.regs.dir & s_r.regs.opt & IRQ_CAP & ~TRUE_OD;

    // ***************************************************************
    // per-pin detectors
    // ***************************************************************
    for (genvar i = 0; i < 8; i++) begin : g_det
        gpx_evt_det u_det (
            .sys_clk_i(sys_clk_i),
            .sys_rst_i(sys_rst_i),
            .pin_i(pad_in_i[i]),
            .en_i(irq_en[i]),
            .sens_i(VEC_SEL[i] ? s_r.regs.sens[`GPX_SENS_V1_LSB +: 2]
                               : s_r.regs.sens[`GPX_SENS_V0_LSB +: 2]),
            .evt_o(pin_evt[i])
        );
    end

    // detect first, then OR per vector
    assign vec_evt[0] = |(pin_evt & ~VEC_SEL);
    assign vec_evt[1] = |(pin_evt & VEC_SEL);

    assign sens_wr = reg_wdata_i[3:0];
    assign sens_chg[0] = reg_wr_i && (reg_addr_i == `GPX_OFF_SENS)
                      && (sens_wr[`GPX_SENS_V0_LSB +: 2] != s_r.regs.sens[`GPX_SENS_V0_LSB +: 2]);
    assign sens_chg[1] = reg_wr_i && (reg_addr_i == `GPX_OFF_SENS)
                      && (sens_wr[`GPX_SENS_V1_LSB +: 2] != s_r.regs.sens[`GPX_SENS_V1_LSB +: 2]);

    // ***************************************************************
    // next state
    // ***************************************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `GPX_OFF_DATA: s_nxt.regs.data = reg_wdata_i;
                `GPX_OFF_DIR: s_nxt.regs.dir = reg_wdata_i;
                `GPX_OFF_OPT: s_nxt.regs.opt = reg_wdata_i & ~TRUE_OD;
                `GPX_OFF_SENS: s_nxt.regs.sens = sens_wr;
                default: s_nxt.regs = s_r.regs;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                `GPX_OFF_DATA: s_nxt.rdata = data_view(s_r.regs, pad_in_i, alt_drive_i, alt_out_i);
                `GPX_OFF_DIR: s_nxt.rdata = s_r.regs.dir;
                `GPX_OFF_OPT: s_nxt.rdata = s_r.regs.opt;
                `GPX_OFF_SENS: s_nxt.rdata = {4'h0, s_r.regs.sens};
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        // a new event beats a fetch or sensitivity change in the same cycle
        s_nxt.pend = (s_r.pend & ~(irq_ack_i | sens_chg)) | vec_evt;
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_r.regs.data <= `GPX_RST_PORT;
            s_r.regs.dir <= `GPX_RST_PORT;
            s_r.regs.opt <= `GPX_RST_PORT;
            s_r.regs.sens <= `GPX_RST_SENS;
            s_r.pend <= 2'h0;
            s_r.rdata <= 8'h00;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ***************************************************************
    // pad drive and peripheral input
    // ***************************************************************
    // peripheral wins whenever it drives; open-drain peripherals only pull low
    always_comb begin
        pad_out_o = (alt_drive_i & alt_out_i & ~alt_od_i & ~TRUE_OD)
                  | (~alt_drive_i & push_pull(s_r.regs.dir, s_r.regs.opt) & s_r.regs.data);
        pad_oe_o = (alt_drive_i & ~(alt_od_i | TRUE_OD))
                 | (alt_drive_i & (alt_od_i | TRUE_OD) & ~alt_out_i)
                 | (~alt_drive_i & push_pull(s_r.regs.dir, s_r.regs.opt))
                 | (~alt_drive_i & s_r.regs.dir & ~push_pull(s_r.regs.dir, s_r.regs.opt)
                    & ~s_r.regs.data);
        pad_pullup_o = ~alt_drive_i & ~s_r.regs.dir & s_r.regs.opt
                     & HAS_PULLUP & ~TRUE_OD;
    end

    assign alt_in_o = (s_r.regs.dir & s_r.regs.data) | (~s_r.regs.dir & pad_in_i);

    // ***************************************************************
    // outputs to the cpu
    // ***************************************************************
    assign reg_rdata_o = s_r.rdata;
    assign irq_req_o = s_r.pend & {2{~cpu_irq_mask_i}};
    // wake ignores the cpu mask; low-power modes never touch port state
    assign wake_o = |s_r.pend;

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_in_read;
        reg_rd_i && reg_addr_i == `GPX_OFF_DATA && s_r.regs.dir == 8'h00
            && alt_drive_i == 8'h00 |=> reg_rdata_o == $past(pad_in_i);
    endproperty
    a_in_read: assert property (p_in_read) else $error("input read not pin level");

    property p_out_read;
        reg_rd_i && reg_addr_i == `GPX_OFF_DATA && s_r.regs.dir == 8'hff
            |=> reg_rdata_o == $past(s_r.regs.data);
    endproperty
    a_out_read: assert property (p_out_read) else $error("output read not latch");

    property p_in_no_drive;
        (pad_oe_o & ~s_r.regs.dir & ~alt_drive_i) == 8'h00;
    endproperty
    a_in_no_drive: assert property (p_in_no_drive) else $error("input pin driven");

    property p_push_pull;
        ((s_r.regs.dir & s_r.regs.opt & ~TRUE_OD & ~alt_drive_i)
            & ~(pad_oe_o & ~(pad_out_o ^ s_r.regs.data))) == 8'h00;
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull drive wrong");

    property p_open_drain;
        ((s_r.regs.dir & ~(s_r.regs.opt & ~TRUE_OD) & ~alt_drive_i)
            & (pad_oe_o ^ ~s_r.regs.data | pad_out_o)) == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain drive wrong");

    property p_alt_push;
        ((alt_drive_i & ~alt_od_i & ~TRUE_OD) & ~pad_oe_o) == 8'h00;
    endproperty
    a_alt_push: assert property (p_alt_push) else $error("peripheral not driving");

    property p_alt_in;
        (alt_in_o & s_r.regs.dir) == (s_r.regs.data & s_r.regs.dir);
    endproperty
    a_alt_in: assert property (p_alt_in) else $error("peripheral input not latch");

    property p_fetch_clear;
        irq_ack_i[0] && !vec_evt[0] |=> !s_r.pend[0];
    endproperty
    a_fetch_clear: assert property (p_fetch_clear) else $error("fetch left request");

    property p_sens_clear;
        sens_chg[1] && !vec_evt[1] |=> !s_r.pend[1] ##1 !s_r.pend[1] || $past(vec_evt[1]);
    endproperty
    a_sens_clear: assert property (p_sens_clear) else $error("sensitivity kept request");

    property p_masked;
        cpu_irq_mask_i |-> irq_req_o == 2'h0;
    endproperty
    a_masked: assert property (p_masked) else $error("request through mask");

    property p_set_cause;
        $rose(s_r.pend[0]) |-> |($past(irq_en) & ~VEC_SEL);
    endproperty
    a_set_cause: assert property (p_set_cause) else $error("request without enabled pin");

    property p_toggle_one;
        reg_rd_i |=> ##1 reg_rdata_o == 8'h00 || $past(reg_rd_i);
    endproperty
    a_toggle_one: assert property (p_toggle_one) else $error("read data stood too long");

    // ***************************************************************
    // register effects, pad modes and request paths
    // ***************************************************************
    property p_data_write;
        reg_wr_i && reg_addr_i == `GPX_OFF_DATA |=> s_r.regs.data == $past(reg_wdata_i);
    endproperty
    a_data_write: assert property (p_data_write) else $error("latch not written");

    property p_dir_write;
        reg_wr_i && reg_addr_i == `GPX_OFF_DIR |=> s_r.regs.dir == $past(reg_wdata_i);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction not written");

    property p_opt_write;
        reg_wr_i && reg_addr_i == `GPX_OFF_OPT
            |=> s_r.regs.opt == ($past(reg_wdata_i) & ~TRUE_OD);
    endproperty
    a_opt_write: assert property (p_opt_write) else $error("option write wrong");

    // only software writes move the configuration, in any power mode
    property p_cfg_hold;
        !reg_wr_i |=> s_r.regs == $past(s_r.regs);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("configuration moved");

    property p_pin_read;
        reg_rd_i && reg_addr_i == `GPX_OFF_DATA |=> ((reg_rdata_o ^ $past(pad_in_i))
            & ~$past(s_r.regs.dir) & ~$past(alt_drive_i)) == 8'h00;
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("input bit not pin");

    property p_alt_read;
        reg_rd_i && reg_addr_i == `GPX_OFF_DATA |=> ((reg_rdata_o ^ $past(alt_out_i))
            & ~$past(s_r.regs.dir) & $past(alt_drive_i)) == 8'h00;
    endproperty
    a_alt_read: assert property (p_alt_read) else $error("read missed peripheral");

    property p_latch_read;
        reg_rd_i && reg_addr_i == `GPX_OFF_DATA
            |=> ((reg_rdata_o ^ $past(s_r.regs.data)) & $past(s_r.regs.dir)) == 8'h00;
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("output bit not latch");

    property p_read_idle;
        !reg_rd_i |=> reg_rdata_o == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data unasked");

    property p_float_in;
        ((~s_r.regs.dir & ~s_r.regs.opt & ~alt_drive_i)
            & (pad_pullup_o | pad_oe_o)) == 8'h00;
    endproperty
    a_float_in: assert property (p_float_in) else $error("float input pulled");

    property p_pullup_in;
        (~s_r.regs.dir & s_r.regs.opt & HAS_PULLUP & ~TRUE_OD & ~alt_drive_i
            & ~pad_pullup_o) == 8'h00;
    endproperty
    a_pullup_in: assert property (p_pullup_in) else $error("pull-up missing");

    property p_no_pullup;
        (pad_pullup_o & ~HAS_PULLUP) == 8'h00;
    endproperty
    a_no_pullup: assert property (p_no_pullup) else $error("pull-up on bare pin");

    property p_od_pin;
        ((pad_out_o | pad_pullup_o) & TRUE_OD) == 8'h00;
    endproperty
    a_od_pin: assert property (p_od_pin) else $error("drain pin pulled high");

    property p_alt_value;
        ((alt_drive_i & ~alt_od_i & ~TRUE_OD) & (pad_out_o ^ alt_out_i)) == 8'h00;
    endproperty
    a_alt_value: assert property (p_alt_value) else $error("peripheral value lost");

    property p_alt_od;
        ((alt_drive_i & (alt_od_i | TRUE_OD))
            & (pad_out_o | (pad_oe_o ^ ~alt_out_i))) == 8'h00;
    endproperty
    a_alt_od: assert property (p_alt_od) else $error("peripheral drain wrong");

    property p_irq_mode;
        (irq_en & (s_r.regs.dir | ~IRQ_CAP)) == 8'h00;
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("interrupt on wrong pin");

    property p_vec1_set;
        (|(pin_evt & VEC_SEL)) |=> s_r.pend[1];
    endproperty
    a_vec1_set: assert property (p_vec1_set) else $error("vector 1 event lost");

    property p_vec0_set;
        (|(pin_evt & ~VEC_SEL)) |=> s_r.pend[0];
    endproperty
    a_vec0_set: assert property (p_vec0_set) else $error("vector 0 event lost");

    property p_wake;
        s_r.pend != 2'h0 |-> wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("request without wake");

    property p_sens_keep;
        reg_wr_i && reg_addr_i == `GPX_OFF_SENS && s_r.pend[0] && !irq_ack_i[0]
            && reg_wdata_i[`GPX_SENS_V0_LSB +: 2] == s_r.regs.sens[`GPX_SENS_V0_LSB +: 2]
            |=> s_r.pend[0];
    endproperty
    a_sens_keep: assert property (p_sens_keep) else $error("same code cleared");

    c_irq_fetch: cover property (s_r.pend[0] ##1 irq_ack_i[0]);
    c_alt_read: cover property (reg_rd_i && (alt_drive_i & ~s_r.regs.dir) != 8'h00);
    c_wake: cover property ($rose(wake_o) && cpu_irq_mask_i);
    c_sens_clear: cover property (sens_chg[0] && s_r.pend[0]);
    c_vec1_req: cover property (irq_req_o[1]);

endmodule // gpx_port

/* File: testbench/gpx_pin_model.sv */
// pin world outside the port: pad drive, pull-ups and external drivers
// assumes the port samples pad levels on sys_clk_i
`timescale 1ns/1ps

module gpx_pin_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] pad_out_i,
    input wire logic [7:0] pad_oe_i,
    input wire logic [7:0] pad_pullup_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] pad_lvl_o
);
    // ***************************************************************
    // level resolution
    // ***************************************************************
    logic [7:0] flip_r = 8'h00;

    // an undriven pin wanders every cycle, so no stale level reads as valid
    always_ff @(posedge sys_clk_i) begin
        flip_r <= ~flip_r;
    end

    // port drive wins over the outside; pull-up holds released pins high
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe_i[i]) begin
                pad_lvl_o[i] = pad_out_i[i];
            end else if (ext_en_i[i]) begin
                pad_lvl_o[i] = ext_val_i[i];
            end else if (pad_pullup_i[i]) begin
                pad_lvl_o[i] = 1'b1;
            end else begin
                pad_lvl_o[i] = flip_r[i];
            end
        end
    end
endmodule // gpx_pin_model

/* File: testbench/gpx_port_test.sv */
// register-level tests of the eight-pin port
// assumes pins 0-3 interrupt-capable, pin 3 without pull-up, pins 6-7 true open-drain
`timescale 1ns/1ps

module gpx_port_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [7:0] wd = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] adrv = 8'h00;
    logic [7:0] aout = 8'h00;
    logic [7:0] aod = 8'h00;
    logic [7:0] evl = 8'hff;
    logic [7:0] een = 8'hff;
    logic msk = 1'b0;
    logic [1:0] ack = 2'h0;
    logic [1:0] s;
    logic [7:0] rdat, pout, poe, ppu, ain, lvl;
    logic [1:0] irq;
    logic wake;
    int err_total = 0;
    int checked = 0;

    initial begin
        forever #10 clk = ~clk;
    end

    gpx_port #(.IRQ_CAP(8'h0f), .HAS_PULLUP(8'hf7), .TRUE_OD(8'hc0), .VEC_SEL(8'h0c)) dut (
        .sys_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .pad_in_i(lvl),
        .pad_out_o(pout), .pad_oe_o(poe), .pad_pullup_o(ppu), .alt_drive_i(adrv),
        .alt_out_i(aout), .alt_od_i(aod), .alt_in_o(ain), .cpu_irq_mask_i(msk),
        .irq_ack_i(ack), .irq_req_o(irq), .wake_o(wake));

    gpx_pin_model pins (.sys_clk_i(clk), .pad_out_i(pout), .pad_oe_i(poe),
        .pad_pullup_i(ppu), .ext_en_i(een), .ext_val_i(evl), .pad_lvl_o(lvl));

    // ***************************************************************
    // bus and compare tasks
    // ***************************************************************
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmpi(input logic [1:0] e);
        cmp({6'h00, irq}, {6'h00, e});
    endtask

    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp(rdat, e);
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic setp(input logic [7:0] v);
        @(posedge clk);
        evl <= v;
    endtask

    task automatic ackp(input logic [1:0] v);
        @(posedge clk);
        ack <= v;
        @(posedge clk);
        ack <= 2'h0;
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // whole run is under two hundred cycles; this span leaves ample margin
    initial begin
        #100000;
        err_total++;
        stop_test();
    end

    // ***************************************************************
    // test sequence
    // ***************************************************************
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        waitc(1);
        cmp(poe, 8'h00);
        cmp(ppu, 8'h00);
        cmpi(2'h0);
        rreg(2'h1, 8'h00);
        rreg(2'h2, 8'h00);
        rreg(2'h3, 8'h00);
        wreg(2'h0, 8'ha5);
        setp(8'h3c);
        waitc(1);
        cmp(poe, 8'h00);
        rreg(2'h0, 8'h3c);
        wreg(2'h1, 8'hff);
        wreg(2'h2, 8'h0f);
        waitc(1);
        cmp(poe, 8'h5f);
        cmp(pout, 8'h05);
        rreg(2'h0, 8'ha5);
        wreg(2'h2, 8'hff);
        rreg(2'h2, 8'h3f);
        cmp(poe, 8'h7f);
        cmp(pout, 8'h25);
        wreg(2'h1, 8'h00);
        waitc(1);
        cmp(ppu, 8'h37);
        // outside lets go of pins 4 and 5: only the pull-ups hold them high
        @(posedge clk);
        een <= 8'hcf;
        evl <= 8'h0c;
        rreg(2'h0, 8'h3c);
        @(posedge clk);
        een <= 8'hff;
        // every sensitivity code on vector 0 through pin 1
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            setp(8'hff);
            wreg(2'h3, {4'h0, s, s});
            ackp(2'h3);
            waitc(2);
            cmpi(2'h0);
            setp(8'hfd);
            waitc(3);
            cmpi({1'b0, s != 2'h1});
            ackp(2'h1);
            waitc(2);
            cmpi({1'b0, s == 2'h0});
            setp(8'hff);
            waitc(3);
            cmpi({1'b0, s != 2'h2});
            @(posedge clk);
            msk <= 1'b1;
            waitc(1);
            cmpi(2'h0);
            cmp({7'h00, wake}, {7'h00, s != 2'h2});
            @(posedge clk);
            msk <= 1'b0;
            wreg(2'h3, {4'h0, s, s ^ 2'h1});
            waitc(1);
            cmpi(2'h0);
        end
        wreg(2'h3, 8'h00);
        ackp(2'h3);
        setp(8'hf7);
        waitc(3);
        cmpi(2'h2);
        setp(8'hff);
        ackp(2'h3);
        setp(8'hef);
        waitc(3);
        cmpi(2'h0);
        // peripheral takes pins 0 and 1 over plain inputs
        wreg(2'h2, 8'h00);
        setp(8'hf0);
        @(posedge clk);
        adrv <= 8'h03;
        aout <= 8'h01;
        aod <= 8'h02;
        waitc(1);
        cmp(poe, 8'h03);
        cmp(pout, 8'h01);
        rreg(2'h0, 8'hf1);
        cmp(ain, 8'hf1);
        @(posedge clk);
        adrv <= 8'h00;
        setp(8'h00);
        wreg(2'h0, 8'ha5);
        wreg(2'h1, 8'hff);
        waitc(1);
        cmp(ain, 8'ha5);
        // reset in mid-run must drop a configured port back to inputs
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        waitc(1);
        cmp(poe, 8'h00);
        rreg(2'h1, 8'h00);
        stop_test();
    end
endmodule // gpx_port_test
